// ---- core/psrrl_pkg.sv ----
// Package with offsets, field positions, reset values and rate figures of the status bank.
package psrrl_pkg;

  // Management address width and data width.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] OFS_P1_LINK_STATUS_B = 8'h1F;
  localparam logic [7:0] OFS_P2_LINK_STATUS_B = 8'h2F;
  localparam logic [7:0] OFS_P3_LINK_STATUS_B = 8'h3F;
  localparam logic [7:0] OFS_GLOBAL_RESET_CONTROL = 8'h43;

  // Field positions in a link status register.
  localparam int unsigned BIT_XOVER_SCHEME = 7;
  localparam int unsigned BIT_STATUS_RSVD = 6;
  localparam int unsigned BIT_POLARITY_REV = 5;
  localparam int unsigned BIT_TX_FLOW_CTRL = 4;
  localparam int unsigned BIT_RX_FLOW_CTRL = 3;
  localparam int unsigned BIT_SPEED_100 = 2;
  localparam int unsigned BIT_FULL_DUPLEX = 1;
  localparam int unsigned BIT_FAR_END_FAULT = 0;

  // Field positions in the global reset control register.
  localparam int unsigned BIT_SOFTWARE_RESET = 4;
  localparam int unsigned BIT_CODING_SUBLAYER_RESET = 0;

  // Values after reset.
  localparam logic XOVER_SCHEME_RST = 1'b1;
  localparam logic [7:0] STATUS_FLAGS_RST = 8'h00;
  localparam logic [7:0] GLOBAL_RESET_CONTROL_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Rate limit code layout and code points.
  localparam int unsigned RATE_CODE_W = 7;
  localparam int unsigned RATE_KBPS_W = 17;
  localparam int unsigned NUM_RATE_CH = 6;
  localparam logic [6:0] RATE_CODE_FULL = 7'h00;
  localparam logic [6:0] RATE_CODE_MAX_100 = 7'h63;
  localparam logic [6:0] RATE_CODE_FULL_100 = 7'h64;
  localparam logic [6:0] RATE_CODE_MAX_10 = 7'h09;
  localparam logic [6:0] RATE_CODE_FULL_10 = 7'h0A;
  localparam logic [6:0] RATE_CODE_FINE_FIRST = 7'h65;
  localparam logic [6:0] RATE_CODE_FINE_LAST = 7'h73;
  localparam logic [6:0] RATE_CODE_FINE_BASE = 7'h64;

  // Rate figures in kbps.
  localparam logic [16:0] KBPS_PER_MBPS = 17'h003E8;
  localparam logic [16:0] KBPS_FINE_STEP = 17'h00040;
  localparam logic [16:0] KBPS_LINK_100 = 17'h186A0;
  localparam logic [16:0] KBPS_LINK_10 = 17'h02710;

endpackage : psrrl_pkg

// ---- core/psrrl_rate_decode.sv ----
// Decoder from a 7-bit rate limit code and link speed to an allowed rate in kbps.
`timescale 1ns/1ps
`default_nettype none

module psrrl_rate_decode (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Code and the port's resolved speed.
  input wire logic [6:0] i_code,
  input wire logic i_speed_100,
  // Decoded rate.
  output logic [16:0] o_rate_kbps,
  output logic o_unlimited
);

  // Multiply a whole-megabit code into kbps.
  function automatic logic [16:0] mbps_to_kbps(input logic [6:0] code);
    logic [23:0] prod;
    prod = {17'h00000, code} * {7'h00, psrrl_pkg::KBPS_PER_MBPS};
    return prod[16:0];
  endfunction : mbps_to_kbps

  logic [16:0] rate_d;
  logic unl_d;
  logic [16:0] rate_q;
  logic unl_q;
  logic [16:0] link_kbps;
  logic [6:0] fine_idx;
  logic [23:0] fine_prod;

  // Codes that name no rate at this speed are read as no limit.
  always_comb begin
    link_kbps = i_speed_100 ? psrrl_pkg::KBPS_LINK_100 : psrrl_pkg::KBPS_LINK_10;
    fine_idx = i_code - psrrl_pkg::RATE_CODE_FINE_BASE;
    fine_prod = {17'h00000, fine_idx} * {7'h00, psrrl_pkg::KBPS_FINE_STEP};
    rate_d = link_kbps;
    unl_d = 1'b1;
    if (i_code >= psrrl_pkg::RATE_CODE_FINE_FIRST && i_code <= psrrl_pkg::RATE_CODE_FINE_LAST) begin
      rate_d = fine_prod[16:0];
      unl_d = 1'b0;
    end else if (i_speed_100) begin
      if (i_code != psrrl_pkg::RATE_CODE_FULL && i_code <= psrrl_pkg::RATE_CODE_MAX_100) begin
        rate_d = mbps_to_kbps(i_code);
        unl_d = 1'b0;
      end else begin
        rate_d = link_kbps;
        unl_d = 1'b1;
      end
    end else begin
      if (i_code != psrrl_pkg::RATE_CODE_FULL && i_code <= psrrl_pkg::RATE_CODE_MAX_10) begin
        rate_d = mbps_to_kbps(i_code);
        unl_d = 1'b0;
      end else begin
        rate_d = link_kbps;
        unl_d = 1'b1;
      end
    end
  end

  // Registered result.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rate_q <= psrrl_pkg::KBPS_LINK_10;
      unl_q <= 1'b1;
    end else begin
      rate_q <= rate_d;
      unl_q <= unl_d;
    end
  end

  assign o_rate_kbps = rate_q;
  assign o_unlimited = unl_q;

endmodule : psrrl_rate_decode

`default_nettype wire

// ---- core/psrrl_status_track.sv ----
// One port's link status register: crossover select bit plus tracked link conditions.
`timescale 1ns/1ps
`default_nettype none

module psrrl_status_track #(
  parameter bit HAS_PHY = 1'b1,
  parameter bit HAS_FAR_END_FAULT = 1'b1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Software write of the crossover select bit.
  input wire logic i_xover_wr,
  input wire logic i_xover_wdata,
  // Link conditions from the PHY or MII.
  input wire logic i_polarity_rev,
  input wire logic i_tx_flow_ctrl,
  input wire logic i_rx_flow_ctrl,
  input wire logic i_speed_100,
  input wire logic i_full_duplex,
  input wire logic i_far_end_fault,
  // Register view and steering outputs.
  output logic [7:0] o_status_byte,
  output logic o_xover_scheme,
  output logic o_speed_100
);

  logic xover_q;
  logic xover_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // Next values: the select bit takes writes, the flags follow the link every cycle.
  always_comb begin
    xover_d = i_xover_wr ? i_xover_wdata : xover_q;
    flags_d = psrrl_pkg::STATUS_FLAGS_RST;
    flags_d[psrrl_pkg::BIT_STATUS_RSVD] = 1'b0;
    // Polarity only means something on a copper port running at 10 Mbps.
    flags_d[psrrl_pkg::BIT_POLARITY_REV] = HAS_PHY & i_polarity_rev & ~i_speed_100;
    flags_d[psrrl_pkg::BIT_TX_FLOW_CTRL] = i_tx_flow_ctrl;
    flags_d[psrrl_pkg::BIT_RX_FLOW_CTRL] = i_rx_flow_ctrl;
    flags_d[psrrl_pkg::BIT_SPEED_100] = i_speed_100;
    flags_d[psrrl_pkg::BIT_FULL_DUPLEX] = i_full_duplex;
    flags_d[psrrl_pkg::BIT_FAR_END_FAULT] = HAS_FAR_END_FAULT & i_far_end_fault;
  end

  // Registers; the flags are sampled continuously so reads show the present link.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      xover_q <= psrrl_pkg::XOVER_SCHEME_RST;
      flags_q <= psrrl_pkg::STATUS_FLAGS_RST;
    end else begin
      xover_q <= xover_d;
      flags_q <= flags_d;
    end
  end

  // The port without a PHY keeps the stored bit but drives nothing from it.
  assign o_xover_scheme = HAS_PHY ? xover_q : psrrl_pkg::XOVER_SCHEME_RST;
  assign o_speed_100 = flags_q[psrrl_pkg::BIT_SPEED_100];

  // Byte as software sees it.
  always_comb begin
    o_status_byte = flags_q;
    o_status_byte[psrrl_pkg::BIT_XOVER_SCHEME] = xover_q;
  end

endmodule : psrrl_status_track

`default_nettype wire

// ---- core/psrrl_top.sv ----
// Port link status registers, global reset control and rate limit decoding of a 3-port switch.
//
// How it works
// - Status bit 7 is read/write crossover scheme select, 1 default, resets 1.
// - Port 3 has no PHY, so its crossover select does nothing.
// - Bit 5 reads 1 for reversed polarity, only at 10 Mbps, never port 3.
// - Bit 4 shows transmit flow control active; resets to 0.
// - Bit 3 shows receive flow control active; resets to 0.
// - Bit 2 shows link speed, 1 for 100 Mbps; resets to 0.
// - Bit 1 shows duplex, 1 for full; resets to 0.
// - Bit 0 shows far-end fault, on port 1 only.
// - Bit 6 is reserved, read-only zero; software leaves it alone.
// - Reset register 0x43 bit 4 returns all other registers to reset values; 0x43 itself holds.
// - Reset register bit 0 resets the PHY coding sublayer; 0 clears it.
// - Rate limit codes are 7 bits, decoded by the port's link speed.
// - At 100 Mbps codes 1 to 0x63 limit to that many Mbps.
// - At 100 Mbps code 0 or 0x64 means no limit.
// - At 10 Mbps codes 1 to 9 limit in Mbps; 0 or 0x0A unlimited.
// - Codes 0x65 to 0x73 give 64 to 960 kbps in 64 kbps steps.
`timescale 1ns/1ps
`default_nettype none

module psrrl_top (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Management port.
  input wire logic [7:0] I_MGMT_ADDR,
  input wire logic [7:0] I_MGMT_WDATA,
  input wire logic I_MGMT_WR,
  input wire logic I_MGMT_RD,
  output logic [7:0] O_MGMT_RDATA,
  output logic O_MGMT_RVALID,
  // Link conditions, one bit per port, port 1 in bit 0.
  input wire logic [2:0] I_POLARITY_REV,
  input wire logic [2:0] I_TX_FLOW_CTRL,
  input wire logic [2:0] I_RX_FLOW_CTRL,
  input wire logic [2:0] I_SPEED_100,
  input wire logic [2:0] I_FULL_DUPLEX,
  input wire logic [2:0] I_FAR_END_FAULT,
  // Crossover scheme select toward the two PHYs.
  output logic O_P1_CROSSOVER_SCHEME_SELECT,
  output logic O_P2_CROSSOVER_SCHEME_SELECT,
  // Reset requests toward the rest of the chip.
  output logic O_SOFTWARE_RESET,
  output logic O_CODING_SUBLAYER_RESET,
  // Rate limit codes: channel 2*(port-1) is ingress, the next one egress.
  input wire logic [41:0] I_RATE_CODES,
  output logic [101:0] O_RATE_KBPS,
  output logic [5:0] O_RATE_UNLIMITED
);

  // Address match helper, used for every write decode.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : hit

  logic [7:0] rst_ctrl_q;
  logic [7:0] rst_ctrl_d;
  logic bank_srst;
  logic [2:0] xover_wr;
  logic [7:0] status_byte [3];
  logic [1:0] xover_sel;
  logic [2:0] speed_100;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_d;
  logic rvalid_q;

  // Reset control register next value; only bits 4 and 0 are implemented.
  always_comb begin
    rst_ctrl_d = rst_ctrl_q;
    if (I_MGMT_WR && hit(I_MGMT_ADDR, psrrl_pkg::OFS_GLOBAL_RESET_CONTROL)) begin
      rst_ctrl_d = psrrl_pkg::GLOBAL_RESET_CONTROL_RST;
      rst_ctrl_d[psrrl_pkg::BIT_SOFTWARE_RESET] =
        I_MGMT_WDATA[psrrl_pkg::BIT_SOFTWARE_RESET];
      rst_ctrl_d[psrrl_pkg::BIT_CODING_SUBLAYER_RESET] =
        I_MGMT_WDATA[psrrl_pkg::BIT_CODING_SUBLAYER_RESET];
    end
  end

  // The reset register sits outside the software reset so the request holds until cleared.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      rst_ctrl_q <= psrrl_pkg::GLOBAL_RESET_CONTROL_RST;
    end else begin
      rst_ctrl_q <= rst_ctrl_d;
    end
  end

  // Every other register is held at its reset value while software reset stands.
  assign bank_srst = I_SRST | rst_ctrl_q[psrrl_pkg::BIT_SOFTWARE_RESET];
  assign O_SOFTWARE_RESET = rst_ctrl_q[psrrl_pkg::BIT_SOFTWARE_RESET];
  assign O_CODING_SUBLAYER_RESET = rst_ctrl_q[psrrl_pkg::BIT_CODING_SUBLAYER_RESET];

  // Write strobes for the three status registers; writes are ignored under software reset.
  always_comb begin
    xover_wr[0] = I_MGMT_WR & ~bank_srst & hit(I_MGMT_ADDR, psrrl_pkg::OFS_P1_LINK_STATUS_B);
    xover_wr[1] = I_MGMT_WR & ~bank_srst & hit(I_MGMT_ADDR, psrrl_pkg::OFS_P2_LINK_STATUS_B);
    xover_wr[2] = I_MGMT_WR & ~bank_srst & hit(I_MGMT_ADDR, psrrl_pkg::OFS_P3_LINK_STATUS_B);
  end

  // Port 1: PHY with far-end fault reporting.
  psrrl_status_track #(
    .HAS_PHY(1'b1),
    .HAS_FAR_END_FAULT(1'b1)
  ) u_port1_status (
    .i_clk(I_CORE_CLK),
    .i_srst(bank_srst),
    .i_xover_wr(xover_wr[0]),
    .i_xover_wdata(I_MGMT_WDATA[psrrl_pkg::BIT_XOVER_SCHEME]),
    .i_polarity_rev(I_POLARITY_REV[0]),
    .i_tx_flow_ctrl(I_TX_FLOW_CTRL[0]),
    .i_rx_flow_ctrl(I_RX_FLOW_CTRL[0]),
    .i_speed_100(I_SPEED_100[0]),
    .i_full_duplex(I_FULL_DUPLEX[0]),
    .i_far_end_fault(I_FAR_END_FAULT[0]),
    .o_status_byte(status_byte[0]),
    .o_xover_scheme(xover_sel[0]),
    .o_speed_100(speed_100[0])
  );

  // Port 2: PHY without far-end fault reporting.
  psrrl_status_track #(
    .HAS_PHY(1'b1),
    .HAS_FAR_END_FAULT(1'b0)
  ) u_port2_status (
    .i_clk(I_CORE_CLK),
    .i_srst(bank_srst),
    .i_xover_wr(xover_wr[1]),
    .i_xover_wdata(I_MGMT_WDATA[psrrl_pkg::BIT_XOVER_SCHEME]),
    .i_polarity_rev(I_POLARITY_REV[1]),
    .i_tx_flow_ctrl(I_TX_FLOW_CTRL[1]),
    .i_rx_flow_ctrl(I_RX_FLOW_CTRL[1]),
    .i_speed_100(I_SPEED_100[1]),
    .i_full_duplex(I_FULL_DUPLEX[1]),
    .i_far_end_fault(I_FAR_END_FAULT[1]),
    .o_status_byte(status_byte[1]),
    .o_xover_scheme(xover_sel[1]),
    .o_speed_100(speed_100[1])
  );

  // Port 3: media-independent interface, no PHY and no far-end fault.
  psrrl_status_track #(
    .HAS_PHY(1'b0),
    .HAS_FAR_END_FAULT(1'b0)
  ) u_port3_status (
    .i_clk(I_CORE_CLK),
    .i_srst(bank_srst),
    .i_xover_wr(xover_wr[2]),
    .i_xover_wdata(I_MGMT_WDATA[psrrl_pkg::BIT_XOVER_SCHEME]),
    .i_polarity_rev(I_POLARITY_REV[2]),
    .i_tx_flow_ctrl(I_TX_FLOW_CTRL[2]),
    .i_rx_flow_ctrl(I_RX_FLOW_CTRL[2]),
    .i_speed_100(I_SPEED_100[2]),
    .i_full_duplex(I_FULL_DUPLEX[2]),
    .i_far_end_fault(I_FAR_END_FAULT[2]),
    .o_status_byte(status_byte[2]),
    .o_xover_scheme(),
    .o_speed_100(speed_100[2])
  );

  // Only the two PHY ports receive a crossover select.
  assign O_P1_CROSSOVER_SCHEME_SELECT = xover_sel[0];
  assign O_P2_CROSSOVER_SCHEME_SELECT = xover_sel[1];

  // Rate limit decoders, two per port, steered by that port's registered speed.
  for (genvar ch = 0; ch < psrrl_pkg::NUM_RATE_CH; ch++) begin : g_rate
    psrrl_rate_decode u_rate (
      .i_clk(I_CORE_CLK),
      .i_srst(bank_srst),
      .i_code(I_RATE_CODES[ch*7 +: 7]),
      .i_speed_100(speed_100[ch/2]),
      .o_rate_kbps(O_RATE_KBPS[ch*17 +: 17]),
      .o_unlimited(O_RATE_UNLIMITED[ch])
    );
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = I_MGMT_RD;
    if (I_MGMT_RD) begin
      case (I_MGMT_ADDR)
        psrrl_pkg::OFS_P1_LINK_STATUS_B: rdata_d = status_byte[0];
        psrrl_pkg::OFS_P2_LINK_STATUS_B: rdata_d = status_byte[1];
        psrrl_pkg::OFS_P3_LINK_STATUS_B: rdata_d = status_byte[2];
        psrrl_pkg::OFS_GLOBAL_RESET_CONTROL: rdata_d = rst_ctrl_q;
        default: rdata_d = psrrl_pkg::UNMAPPED_READ_VALUE;
      endcase
    end
  end

  // Read data and its valid pulse come from flip-flops, one cycle after the request.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      rdata_q <= psrrl_pkg::UNMAPPED_READ_VALUE;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign O_MGMT_RDATA = rdata_q;
  assign O_MGMT_RVALID = rvalid_q;

endmodule : psrrl_top

`default_nettype wire

// ---- dv/psrrl_monitor.sv ----
// Concurrent checks on the ports of the status, reset control and rate limit bank.
`timescale 1ns/1ps
`default_nettype none

module psrrl_monitor (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Management port.
  input wire logic [7:0] I_MGMT_ADDR,
  input wire logic [7:0] I_MGMT_WDATA,
  input wire logic I_MGMT_WR,
  input wire logic I_MGMT_RD,
  input wire logic [7:0] O_MGMT_RDATA,
  input wire logic O_MGMT_RVALID,
  // Link conditions.
  input wire logic [2:0] I_POLARITY_REV,
  input wire logic [2:0] I_TX_FLOW_CTRL,
  input wire logic [2:0] I_RX_FLOW_CTRL,
  input wire logic [2:0] I_SPEED_100,
  input wire logic [2:0] I_FULL_DUPLEX,
  input wire logic [2:0] I_FAR_END_FAULT,
  // Control outputs.
  input wire logic O_P1_CROSSOVER_SCHEME_SELECT,
  input wire logic O_SOFTWARE_RESET,
  input wire logic O_CODING_SUBLAYER_RESET,
  // Rate limit channels.
  input wire logic [41:0] I_RATE_CODES,
  input wire logic [101:0] O_RATE_KBPS,
  input wire logic [5:0] O_RATE_UNLIMITED
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  // Channel 0 code and port 1 speed, the views the rate checks use.
  logic [6:0] code0;
  logic spd0;
  assign code0 = I_RATE_CODES[6:0];
  assign spd0 = I_SPEED_100[0];

  // No reset of either kind now or one cycle ago, so registers hold live values.
  sequence s_calm;
    !O_SOFTWARE_RESET && !$past(O_SOFTWARE_RESET) && !$past(I_SRST);
  endsequence
  sequence s_rd(logic [7:0] a);
    I_MGMT_RD && I_MGMT_ADDR == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    I_MGMT_WR && I_MGMT_ADDR == a;
  endsequence

  AST_READ_ANSWER: assert property (I_MGMT_RD |=> O_MGMT_RVALID ##1
    (O_MGMT_RVALID == $past(I_MGMT_RD))) else $error("read answer pulse wrong");
  AST_RESET_WRITE: assert property (s_wr(8'h43) |=>
    O_SOFTWARE_RESET == $past(I_MGMT_WDATA[4]) &&
    O_CODING_SUBLAYER_RESET == $past(I_MGMT_WDATA[0])) else $error("reset bits not written");
  AST_XOVER_WRITE: assert property (s_calm ##0 s_wr(8'h1F) |=>
    O_P1_CROSSOVER_SCHEME_SELECT == $past(I_MGMT_WDATA[7])) else $error("crossover not written");
  AST_XOVER_KEEP: assert property (!O_SOFTWARE_RESET && !(I_MGMT_WR && I_MGMT_ADDR == 8'h1F)
    |=> $stable(O_P1_CROSSOVER_SCHEME_SELECT)) else $error("crossover changed unasked");
  AST_SWRST_HOLD: assert property (O_SOFTWARE_RESET |=> O_P1_CROSSOVER_SCHEME_SELECT &&
    O_RATE_UNLIMITED == 6'h3F && O_RATE_KBPS[16:0] == 17'h02710) else $error("soft reset lost");
  AST_READ_P1: assert property (s_calm ##0 s_rd(8'h1F) |=>
    O_MGMT_RDATA == {$past(O_P1_CROSSOVER_SCHEME_SELECT), 1'h0,
    $past(I_POLARITY_REV[0], 2) & ~$past(spd0, 2), $past(I_TX_FLOW_CTRL[0], 2),
    $past(I_RX_FLOW_CTRL[0], 2), $past(spd0, 2), $past(I_FULL_DUPLEX[0], 2),
    $past(I_FAR_END_FAULT[0], 2)}) else $error("port 1 status byte wrong");
  AST_READ_P2: assert property (s_rd(8'h2F) |=>
    O_MGMT_RDATA[6] == 1'h0 && O_MGMT_RDATA[0] == 1'h0) else $error("port 2 fixed bits wrong");
  AST_READ_P3: assert property (s_rd(8'h3F) |=>
    O_MGMT_RDATA[6:5] == 2'h0 && O_MGMT_RDATA[0] == 1'h0) else $error("port 3 fixed bits wrong");
  AST_RATE_FINE: assert property (s_calm ##0 (code0 >= 7'h65 && code0 <= 7'h73) |=>
    O_RATE_KBPS[16:0] == {4'h0, $past(code0) - 7'h64, 6'h00} && !O_RATE_UNLIMITED[0])
    else $error("fine rate wrong");
  AST_RATE_MBPS: assert property (s_calm ##0 ($stable(spd0) && code0 != 7'h00 &&
    code0 <= (spd0 ? 7'h63 : 7'h09)) |=> O_RATE_KBPS[16:0] == $past(code0) * 17'h003E8 &&
    !O_RATE_UNLIMITED[0]) else $error("Mbps rate wrong");
  AST_RATE_FULL: assert property (s_calm ##0 ($stable(spd0) &&
    (code0 == 7'h00 || code0 == (spd0 ? 7'h64 : 7'h0A))) |=> O_RATE_UNLIMITED[0] &&
    O_RATE_KBPS[16:0] == ($past(spd0) ? 17'h186A0 : 17'h02710)) else $error("full rate wrong");

endmodule : psrrl_monitor

`default_nettype wire

// ---- dv/test_psrrl_top.sv ----
// Self-checking bench for the port status, reset control and rate limit bank.
`timescale 1ns/1ps
`default_nettype none

module test_psrrl_top;
  logic clk, srst, wr, rd, rvalid, xo1, xo2, swr, csr;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] pol, txf, rxf, spd, dup, fef;
  logic [41:0] codes;
  logic [101:0] kbps;
  logic [5:0] unl;
  logic [31:0] lfsr = 32'hAA2E;
  int error_cnt = 0;
  int n_compared = 0;
  // Reference state: crossover bits, software reset, coding sublayer reset.
  bit [2:0] m_xo = 3'h7;
  bit m_sw = 1'h0;
  bit m_cs = 1'h0;

  psrrl_top psrrl_top_inst (.I_CORE_CLK(clk), .I_SRST(srst), .I_MGMT_ADDR(addr),
    .I_MGMT_WDATA(wdata), .I_MGMT_WR(wr), .I_MGMT_RD(rd), .O_MGMT_RDATA(rdata),
    .O_MGMT_RVALID(rvalid), .I_POLARITY_REV(pol), .I_TX_FLOW_CTRL(txf), .I_RX_FLOW_CTRL(rxf),
    .I_SPEED_100(spd), .I_FULL_DUPLEX(dup), .I_FAR_END_FAULT(fef),
    .O_P1_CROSSOVER_SCHEME_SELECT(xo1), .O_P2_CROSSOVER_SCHEME_SELECT(xo2),
    .O_SOFTWARE_RESET(swr), .O_CODING_SUBLAYER_RESET(csr), .I_RATE_CODES(codes),
    .O_RATE_KBPS(kbps), .O_RATE_UNLIMITED(unl));

  // Pseudo-random source with a fixed start so runs repeat.
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Expected status byte of port p from the live link inputs.
  function automatic logic [7:0] m_stat(int p);
    if (m_sw) return 8'h80;
    return {m_xo[p], 1'h0, pol[p] & ~spd[p] & (p != 2), txf[p], rxf[p], spd[p], dup[p],
      fef[p] & (p == 0)};
  endfunction : m_stat

  task automatic check(string what, logic [16:0] exp, logic [16:0] act);
    n_compared++;
    if (exp !== act) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask : check

  // One write; the reference state follows the same write.
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk) #1;
    wr = 1'h1;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'h0;
    for (int p = 0; p < 3; p++) begin
      if (!m_sw && a == 8'h1F + 8'(16 * p)) m_xo[p] = d[7];
    end
    if (a == 8'h43) begin
      m_sw = d[4];
      m_cs = d[0];
      if (d[4]) m_xo = 3'h7;
    end
  endtask : wr_reg

  // One read; the answer is due exactly one cycle after the strobe.
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge clk) #1;
    rd = 1'h1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'h0;
    check("rvalid", 17'h00001, {16'h0, rvalid});
    check("rdata", {9'h0, exp}, {9'h0, rdata});
  endtask : rd_chk

  task automatic rd_all();
    for (int p = 0; p < 3; p++) begin
      rd_chk(8'h1F + 8'(16 * p), m_stat(p));
    end
    rd_chk(8'h43, {3'h0, m_sw, 3'h0, m_cs});
    rd_chk(8'h50, 8'h00);
  endtask : rd_all

  task automatic chk_out();
    check("xover1", {16'h0, m_xo[0]}, {16'h0, xo1});
    check("xover2", {16'h0, m_xo[1]}, {16'h0, xo2});
    check("soft_reset", {16'h0, m_sw}, {16'h0, swr});
    check("cs_reset", {16'h0, m_cs}, {16'h0, csr});
  endtask : chk_out

  // Rate of every channel from its code and its port's speed.
  task automatic chk_rates();
    int code, full, exp;
    bit s, lim;
    for (int c = 0; c < 6; c++) begin
      code = codes[7*c +: 7];
      s = spd[c/2] && !m_sw;
      full = s ? 100000 : 10000;
      lim = !m_sw && ((code >= 101 && code <= 115) || (code >= 1 && code <= (s ? 99 : 9)));
      exp = !lim ? full : (code >= 101 ? (code - 100) * 64 : code * 1000);
      check("rate_kbps", 17'(exp), kbps[17*c +: 17]);
      check("unlimited", {16'h0, !lim}, {16'h0, unl[c]});
    end
  endtask : chk_rates

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Free-running core clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Watchdog well beyond the roughly 1100 cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  // Main sequence of tests.
  initial begin
    srst = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    {pol, txf, rxf, spd, dup, fef} = 18'h0;
    codes = 42'h0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'h0;
    chk_out();
    chk_rates();
    rd_all();
    $display("reset values done");
    wr_reg(8'h50, 8'(rnd()));
    for (int i = 0; i < 24; i++) begin
      {pol, txf, rxf, spd, dup, fef} = 18'(rnd());
      wr_reg(8'h1F + 8'(16 * (i % 3)), 8'(rnd()));
      chk_out();
      rd_all();
    end
    $display("link status done");
    for (int i = 0; i < 256; i++) begin
      for (int c = 0; c < 6; c++) begin
        codes[7*c +: 7] = 7'(i + 37 * c);
      end
      spd = i[7] ? 3'h5 : 3'h2;
      repeat (3) @(posedge clk);
      #1;
      chk_rates();
    end
    $display("rate decode done");
    {pol, txf, rxf, spd, dup, fef} = 18'h3FFFF;
    wr_reg(8'h1F, 8'h00);
    wr_reg(8'h2F, 8'h00);
    wr_reg(8'h43, 8'h01);
    chk_out();
    rd_all();
    wr_reg(8'h43, 8'hFF);
    @(posedge clk) #1;
    chk_out();
    wr_reg(8'h1F, 8'h00);
    rd_all();
    chk_rates();
    wr_reg(8'h43, 8'h00);
    @(posedge clk) #1;
    chk_out();
    rd_all();
    chk_rates();
    $display("software reset done");
    end_of_test();
  end

endmodule : test_psrrl_top

bind psrrl_top psrrl_monitor psrrl_monitor_inst (.I_CORE_CLK, .I_SRST, .I_MGMT_ADDR,
  .I_MGMT_WDATA, .I_MGMT_WR, .I_MGMT_RD, .O_MGMT_RDATA, .O_MGMT_RVALID, .I_POLARITY_REV,
  .I_TX_FLOW_CTRL, .I_RX_FLOW_CTRL, .I_SPEED_100, .I_FULL_DUPLEX, .I_FAR_END_FAULT,
  .O_P1_CROSSOVER_SCHEME_SELECT, .O_SOFTWARE_RESET, .O_CODING_SUBLAYER_RESET, .I_RATE_CODES,
  .O_RATE_KBPS, .O_RATE_UNLIMITED);

`default_nettype wire
